// ===== bench/serial_node.sv
// remote serial node: sends shaped frames and decodes the device's serial output
`timescale 1ns/1ps
`default_nettype none
module serial_node (
  // clock
  input  wire logic        clock,
  // setup
  input  wire logic [15:0] div,
  input  wire logic        nine,
  // lines
  output var  logic        line,
  input  wire logic        tx_line,
  // decoded characters
  output var  logic        got,
  output var  logic [8:0]  got_data
);
  int nb;

  always_comb begin
    nb = nine ? 9 : 8;
  end

  initial begin
    line = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n * div) @(negedge clock);
  endtask

  // one frame; bit ob carries op at RT8..RT10, every other tick carries the true level
  task automatic send(input logic [8:0] d, input int ob, input logic [2:0] op, input int gap);
    logic v;
    for (int b = 0; b < nb + 2; b++) begin
      v = (b == 0) ? 1'h0 : (b > nb) ? 1'h1 : d[b-1];
      for (int t = 0; t < 16; t++) begin
        line = (b == ob && t >= 7 && t <= 9) ? op[9-t] : v;
        tick(1);
      end
    end
    line = 1'h1;
    tick(gap);
  endtask

  // a lone low tick that must be rejected as a false start, without raising noise
  task automatic glitch();
    line = 1'h0;
    tick(1);
    line = 1'h1;
    tick(12);
  endtask

  // mid-bit decoder; a low shorter than half a bit is ignored, so polarity flips do no harm
  initial begin
    got = 1'h0;
    got_data = 9'h000;
    forever begin
      @(posedge clock);
      got = 1'h0;
      if (!tx_line) begin
        repeat (8 * div - 1) @(posedge clock);
        if (!tx_line) begin
          got_data = 9'h000;
          for (int i = 0; i < nb; i++) begin
            repeat (16 * div) @(posedge clock);
            got_data[i] = tx_line;
          end
          repeat (16 * div) @(posedge clock);
          got = 1'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench of the serial interface with receive bit recovery
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sci_pkg::*;
  logic               clock = 1'h0;
  logic               rst = 1'h1;
  logic [15:0]        div = 16'h0001;
  logic               tx_en = 1'h0, rx_en = 1'h1, nine = 1'h0, par_en = 1'h0, par_odd = 1'h0;
  logic               tx_inv = 1'h0, rx_inv = 1'h0, single = 1'h0, wake_addr = 1'h0, ir = 1'h0;
  logic [3:0]         ir_w = 4'h4;
  logic               sleep_req = 1'h0, tx_valid = 1'h0, rx_ready = 1'h0, hold = 1'h0;
  logic [8:0]         tx_data = 9'h000;
  logic               line, txd_out, txd_oe, tx_ready, noise, framing, perr, rx_valid;
  logic               overrun, asleep, got;
  logic [8:0]         rx_data, got_data;
  logic [31:0]        seed = 32'hF373;
  logic [31:0]        r;
  logic [ENTRY_W-1:0] rx_q[$];
  logic [8:0]         tx_q[$];
  int                 mismatches = 0, check_count = 0, overruns = 0;
  wire logic          txd_pin = txd_oe ? txd_out : 1'h1;
  wire logic          rxd = line ^ rx_inv;
  wire logic          tx_seen = txd_out ^ tx_inv;

  always #12.5 clock = ~clock;

  sci_bit_recovery dut (.CLOCK(clock), .RST(rst), .BAUD_DIVISOR(div), .TX_ENABLE(tx_en),
    .RX_ENABLE(rx_en), .NINE_BITS(nine), .PARITY_ENABLE(par_en), .PARITY_ODD(par_odd),
    .TX_INVERT(tx_inv), .RX_INVERT(rx_inv), .INFRARED_INVERTED_ENCODING(ir),
    .IR_PULSE_TICKS(ir_w), .SINGLE_WIRE(single), .WAKE_ON_ADDRESS(wake_addr),
    .SLEEP_REQ(sleep_req), .RXD_IN(rxd), .TXD_IN(txd_pin), .TXD_OUT(txd_out),
    .TXD_OE(txd_oe), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .RX_DATA(rx_data), .NOISE_FLAG(noise), .RX_FRAMING(framing), .RX_PARITY_ERR(perr),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_OVERRUN(overrun), .RX_ASLEEP(asleep));

  serial_node node (.clock(clock), .div(div), .nine(nine), .line(line), .tx_line(tx_seen),
    .got(got), .got_data(got_data));

  function automatic logic [8:0] rnd9();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[8:0];
  endfunction

  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seen);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // consumer stalls at random, and stops while hold is set so the buffer really fills
  always @(negedge clock) begin
    r = {23'h0, rnd9()};
    rx_ready <= !hold && (r[0] || r[1]);
  end

  always @(posedge clock) begin
    if (!rst && overrun === 1'h1) overruns++;
    if (!rst && rx_valid === 1'h1 && rx_ready) begin
      if (rx_q.size() > 0) check("rx entry", rx_q.pop_front(), {perr, framing, noise, rx_data});
      else begin
        mismatches++;
        $display("Error rx entry expected none seen %h", rx_data);
      end
    end
  end

  always @(negedge clock) begin
    if (got === 1'h1) begin
      if (tx_q.size() > 0) check("tx char", {3'h0, tx_q.pop_front()}, {3'h0, got_data});
      else begin
        mismatches++;
        $display("Error tx char expected none seen %h", got_data);
      end
    end
  end

  // expectation follows the vote tables; keep low means the device must drop it
  task automatic frame(input logic [8:0] d, input int ob, input logic [2:0] op, input logic keep);
    logic [8:0] e;
    logic [8:0] v9;
    logic       nz, fr, m;
    e = nine ? d : {1'h0, d[7:0]};
    nz = 1'h0;
    fr = 1'h0;
    m = (op[0] & op[1]) | (op[1] & op[2]) | (op[0] & op[2]);
    if (ob == 0) nz = |op;
    else if (ob > 0 && ob <= (nine ? 9 : 8)) begin
      e[ob-1] = m;
      nz = op != 3'h0 && op != 3'h7;
    end else if (ob > 0) begin
      fr = !m;
      nz = op != 3'h0 && op != 3'h7;
    end
    if (keep) rx_q.push_back({par_en & (^e ^ par_odd), fr, nz, e});
    v9 = rnd9();
    node.send(d, ob, op, 3 + int'(v9[2:0]));
  endtask

  task automatic tx_send(input logic [8:0] d);
    logic [8:0] e;
    int         n;
    n = 0;
    e = nine ? d : {1'h0, d[7:0]};
    if (par_en && nine) e[8] = ^d[7:0] ^ par_odd;
    if (par_en && !nine) e[7] = ^d[6:0] ^ par_odd;
    while (tx_ready !== 1'h1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    tx_q.push_back(e);
    tx_valid = 1'h1;
    tx_data = d;
    @(negedge clock);
    tx_valid = 1'h0;
  endtask

  task automatic done(input string name);
    int n;
    n = 0;
    while (rx_q.size() + tx_q.size() > 0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      $display("Error %s queue expected 0 seen %0d", name, rx_q.size() + tx_q.size());
    end
    repeat (20) @(negedge clock);
    $display("test %s done", name);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #1_500_000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (10) @(negedge clock);
    rst = 1'h0;
    repeat (3) @(negedge clock);
    check("reset outputs", 12'h000, {9'h0, tx_ready, txd_oe, rx_valid});
    node.glitch();
    frame(rnd9(), -1, 3'h0, 1'h1);
    for (int i = 0; i < 3; i++) frame(rnd9(), -1, 3'h0, 1'h1);
    done("plain receive");
    for (int p = 0; p < 8; p++) frame(rnd9(), 3, 3'(p), 1'h1);
    for (int p = 0; p < 8; p++) frame(rnd9(), 0, 3'(p), 1'h1);
    for (int p = 0; p < 8; p++) frame(rnd9(), 9, 3'(p), 1'h1);
    done("vote tables");
    tx_en = 1'h1;
    repeat (3) @(negedge clock);
    check("tx enable", 12'h001, {11'h0, txd_oe});
    nine = 1'h1;
    par_en = 1'h1;
    for (int o = 0; o < 2; o++) begin
      par_odd = 1'(o);
      frame(rnd9(), 10, 3'h1, 1'h1);
      frame(rnd9(), -1, 3'h0, 1'h1);
      tx_send(rnd9());
    end
    done("nine bits parity");
    nine = 1'h0;
    par_en = 1'h0;
    fork
      begin
        tx_send(9'h0C3);
        tx_send(rnd9());
      end
      frame(rnd9(), -1, 3'h0, 1'h1);
    join
    done("full duplex");
    rx_en = 1'h0;
    fork
      tx_send(rnd9());
      frame(rnd9(), -1, 3'h0, 1'h0);
    join
    rx_en = 1'h1;
    done("receiver off");
    tx_inv = 1'h1;
    rx_inv = 1'h1;
    repeat (40) @(negedge clock);
    fork
      tx_send(rnd9());
      frame(rnd9(), 2, 3'h4, 1'h1);
    join
    done("inverted lines");
    tx_inv = 1'h0;
    rx_inv = 1'h0;
    repeat (40) @(negedge clock);
    div = 16'h0003;
    fork
      tx_send(rnd9());
      frame(rnd9(), 5, 3'h6, 1'h1);
    join
    done("divisor three");
    div = 16'h0001;
    single = 1'h1;
    repeat (20) @(negedge clock);
    rx_q.push_back(12'h0A5);
    tx_send(9'h0A5);
    done("single wire");
    ir = 1'h1;
    repeat (20) @(negedge clock);
    for (int w = 2; w < 6; w += 3) begin
      ir_w = 4'(w);
      rx_q.push_back(12'h036);
      tx_send(9'h036);
      // the node reads only full-width bits, so the loop back is the check here
      tx_q.delete();
      done("infrared loop");
    end
    ir = 1'h0;
    ir_w = 4'h4;
    repeat (20) @(negedge clock);
    single = 1'h0;
    hold = 1'h1;
    overruns = 0;
    frame(rnd9(), 2, 3'h1, 1'h1);
    frame(rnd9(), 9, 3'h4, 1'h1);
    frame(rnd9(), -1, 3'h0, 1'h0);
    repeat (20) @(negedge clock);
    check("overrun pulses", 12'h001, 12'(overruns));
    hold = 1'h0;
    done("buffer full");
    nine = 1'h1;
    wake_addr = 1'h1;
    sleep_req = 1'h1;
    @(negedge clock);
    sleep_req = 1'h0;
    repeat (3) @(negedge clock);
    check("asleep", 12'h001, {11'h0, asleep});
    frame(9'h055, -1, 3'h0, 1'h0);
    frame(9'h1A5, -1, 3'h0, 1'h1);
    check("address wake", 12'h000, {11'h0, asleep});
    wake_addr = 1'h0;
    sleep_req = 1'h1;
    @(negedge clock);
    sleep_req = 1'h0;
    frame(rnd9(), -1, 3'h0, 1'h0);
    repeat (200) @(negedge clock);
    check("idle wake", 12'h000, {11'h0, asleep});
    frame(rnd9(), -1, 3'h0, 1'h1);
    done("wakeup");
    stop_test();
  end
endmodule
`default_nettype wire

// ===== pkg/char_stream_if.sv
// valid/ready stream of received characters between design modules
`timescale 1ns/1ps
`default_nettype none
interface char_stream_if #(parameter int W = 12);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== pkg/sci_pkg.sv
// shared constants and types of the serial receiver and transmitter
package sci_pkg;
  localparam int         CLOCK_HZ      = 40_000_000;
  localparam int         RT_PER_BIT    = 16;
  localparam logic [3:0] RT3           = 4'h2;
  localparam logic [3:0] RT5           = 4'h4;
  localparam logic [3:0] RT7           = 4'h6;
  localparam logic [3:0] RT8           = 4'h7;
  localparam logic [3:0] RT9           = 4'h8;
  localparam logic [3:0] RT10          = 4'h9;
  localparam logic [3:0] RT_LAST       = 4'hF;
  localparam logic [4:0] IR_HOLD_TICKS = 5'h10;
  localparam logic [3:0] BITS_8        = 4'h8;
  localparam logic [3:0] BITS_9        = 4'h9;
  localparam logic [3:0] FRAME_EXTRA   = 4'h2;
  localparam logic [8:0] DATA_RESET    = 9'h000;
  localparam logic [10:0] TX_IDLE_FRAME = 11'h7FF;
  localparam logic [15:0] BAUD_RESET   = 16'h0000;
  localparam int         ENTRY_W       = 12;
  localparam int         BUFFER_DEPTH  = 2;

  typedef enum logic [1:0] {R_HUNT, R_START, R_DATA, R_STOP} rx_state_e;
endpackage

// ===== rtl/char_buffer.sv
// two-entry character buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module char_buffer #(
  parameter int W     = 12,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic    clock,
  input wire logic    rst,
  // streams
  char_stream_if.snk  fill,
  char_stream_if.src  drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   count;
  logic [AW:0]   next_count;
  logic          room;
  logic          have;
  logic          push;
  logic          pop;

  assign push = fill.valid && room;
  assign pop  = have && drain.ready;

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
      room  <= 1'b1;
      have  <= 1'b0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
      end
      count <= next_count;
      // flags registered so the ports never see a combinational path
      room  <= next_count != (AW+1)'(DEPTH);
      have  <= next_count != '0;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp] <= fill.data;
    end
  end

  assign fill.ready  = room;
  assign drain.valid = have;
  assign drain.data  = mem[rp];
endmodule
`default_nettype wire

// ===== rtl/sci_bit_recovery.sv
// serial interface with oversampled receive bit recovery
`timescale 1ns/1ps
`default_nettype none
module sci_bit_recovery (
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // configuration
  input  wire logic [15:0] BAUD_DIVISOR,
  input  wire logic       TX_ENABLE,
  input  wire logic       RX_ENABLE,
  input  wire logic       NINE_BITS,
  input  wire logic       PARITY_ENABLE,
  input  wire logic       PARITY_ODD,
  input  wire logic       TX_INVERT,
  input  wire logic       RX_INVERT,
  input  wire logic       INFRARED_INVERTED_ENCODING,
  input  wire logic [3:0] IR_PULSE_TICKS,
  input  wire logic       SINGLE_WIRE,
  input  wire logic       WAKE_ON_ADDRESS,
  input  wire logic       SLEEP_REQ,
  // serial pins
  input  wire logic       RXD_IN,
  input  wire logic       TXD_IN,
  output var  logic       TXD_OUT,
  output var  logic       TXD_OE,
  // transmit stream
  input  wire logic [8:0] TX_DATA,
  input  wire logic       TX_VALID,
  output var  logic       TX_READY,
  // receive stream
  output      logic [8:0] RX_DATA,
  output      logic       NOISE_FLAG,
  output      logic       RX_FRAMING,
  output      logic       RX_PARITY_ERR,
  output      logic       RX_VALID,
  input  wire logic       RX_READY,
  // status
  output var  logic       RX_OVERRUN,
  output var  logic       RX_ASLEEP
);
  import sci_pkg::*;

  // no mode inputs exist, so the block acts alike in every chip mode

  function automatic logic maj3(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [15:0]  baud_cnt;
  logic         rt_tick;
  logic [1:0]   rx_sync;
  logic         rx_pin;
  logic [4:0]   ir_hold;
  logic         rx_line;
  logic [3:0]   nbits;
  logic [7:0]   idle_limit;
  rx_state_e    rx_state;
  logic [3:0]   rt;
  logic [1:0]   ver;
  logic [1:0]   vote;
  logic [3:0]   bit_cnt;
  logic [8:0]   shift;
  logic         noise;
  logic         prev_line;
  logic         char_done;
  logic         char_frame;
  logic         data_vote;
  logic         unanimous;
  logic         start_reject;
  logic [8:0]   rx_data;
  logic         par_err;
  logic         addr_bit;
  logic         wake_addr;
  logic         wr_valid;
  logic [ENTRY_W-1:0] wr_data;
  logic [7:0]   idle_cnt;
  logic         tx_busy;
  logic [10:0]  tx_shift;
  logic [3:0]   tx_rt;
  logic [3:0]   tx_left;
  logic [8:0]   tx_d;
  logic [10:0]  tx_frame;
  logic         tx_wire;

  char_stream_if #(.W(ENTRY_W)) fill ();
  char_stream_if #(.W(ENTRY_W)) drain ();

  // oversampling tick; a zero divisor parks both directions
  always_ff @(posedge CLOCK) begin
    if (RST || BAUD_DIVISOR == BAUD_RESET) begin
      baud_cnt <= BAUD_RESET;
      rt_tick  <= 1'b0;
    end else if (baud_cnt >= BAUD_DIVISOR - 16'h0001) begin
      baud_cnt <= BAUD_RESET;
      rt_tick  <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h0001;
      rt_tick  <= 1'b0;
    end
  end

  assign nbits      = NINE_BITS ? BITS_9 : BITS_8;
  assign idle_limit = {nbits + FRAME_EXTRA, 4'h0};

  // single wire listens on the transmit pin
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rx_sync <= 2'b11;
    end else begin
      rx_sync <= {rx_sync[0], SINGLE_WIRE ? TXD_IN : RXD_IN};
    end
  end
  assign rx_pin = rx_sync[1] ^ RX_INVERT;

  // short infrared pulses are stretched to one bit so the voter sees them
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ir_hold <= 5'h00;
    end else if (INFRARED_INVERTED_ENCODING && !rx_pin) begin
      ir_hold <= IR_HOLD_TICKS;
    end else if (rt_tick && ir_hold != 5'h00) begin
      ir_hold <= ir_hold - 5'h01;
    end
  end
  assign rx_line = INFRARED_INVERTED_ENCODING ? (ir_hold == 5'h00) : rx_pin;

  assign data_vote    = maj3({rx_line, vote});
  assign unanimous    = (&{rx_line, vote}) | ~(|{rx_line, vote});
  assign start_reject = maj3({rx_line, ver});

  // receive bit recovery, votes on three ticks of sixteen per bit
  always_ff @(posedge CLOCK) begin
    if (RST || !RX_ENABLE) begin
      rx_state   <= R_HUNT;
      rt         <= 4'h0;
      ver        <= 2'b00;
      vote       <= 2'b00;
      bit_cnt    <= 4'h0;
      shift      <= DATA_RESET;
      noise      <= 1'b0;
      prev_line  <= 1'b1;
      char_done  <= 1'b0;
      char_frame <= 1'b0;
    end else begin
      char_done <= 1'b0;
      if (rt_tick) begin
        prev_line <= rx_line;
        rt        <= rt + 4'h1;
        if (rt == RT8) begin
          vote[0] <= rx_line;
        end
        if (rt == RT9) begin
          vote[1] <= rx_line;
        end
        case (rx_state)
          R_HUNT: begin
            rt <= 4'h0;
            if (prev_line && !rx_line) begin
              rx_state <= R_START;
              rt       <= 4'h1;
              noise    <= 1'b0;
            end
          end
          R_START: begin
            if (rt == RT3) begin
              ver[0] <= rx_line;
            end
            if (rt == RT5) begin
              ver[1] <= rx_line;
            end
            if (rt == RT7) begin
              if (start_reject) begin
                rx_state <= R_HUNT;
                rt       <= 4'h0;
              end else if (|{rx_line, ver}) begin
                noise <= 1'b1;
              end
            end
            if (rt == RT10 && |{rx_line, vote}) begin
              noise <= 1'b1;
            end
            if (rt == RT_LAST) begin
              rx_state <= R_DATA;
              bit_cnt  <= 4'h0;
            end
          end
          R_DATA: begin
            if (rt == RT10) begin
              shift <= {data_vote, shift[8:1]};
              if (!unanimous) begin
                noise <= 1'b1;
              end
            end
            if (rt == RT_LAST) begin
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == nbits - 4'h1) begin
                rx_state <= R_STOP;
              end
            end
          end
          R_STOP: begin
            if (rt == RT10) begin
              char_done  <= 1'b1;
              char_frame <= !data_vote;
              if (!unanimous) begin
                noise <= 1'b1;
              end
              // hunting resumes at once so a short stop still resyncs
              rx_state <= R_HUNT;
              rt       <= 4'h0;
            end
          end
          default: begin
            rx_state <= R_HUNT;
          end
        endcase
      end
    end
  end

  assign rx_data   = NINE_BITS ? shift : {1'b0, shift[8:1]};
  assign par_err   = PARITY_ENABLE && ((^rx_data) != PARITY_ODD);
  assign addr_bit  = NINE_BITS ? rx_data[8] : rx_data[7];
  assign wake_addr = char_done && WAKE_ON_ADDRESS && addr_bit;

  // sleeping receiver drops characters until one of the two wakeups
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RX_ASLEEP <= 1'b0;
      idle_cnt  <= 8'h00;
    end else begin
      if (!RX_ASLEEP || !rx_line) begin
        idle_cnt <= 8'h00;
      end else if (rt_tick && idle_cnt != idle_limit) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
      if (SLEEP_REQ) begin
        RX_ASLEEP <= 1'b1;
      end else if (wake_addr || (!WAKE_ON_ADDRESS && idle_cnt == idle_limit)) begin
        RX_ASLEEP <= 1'b0;
      end
    end
  end

  // flags are written with the data they belong to
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_valid   <= 1'b0;
      wr_data    <= '0;
      RX_OVERRUN <= 1'b0;
    end else begin
      wr_valid   <= char_done && (!RX_ASLEEP || wake_addr);
      wr_data    <= {par_err, char_frame, noise, rx_data};
      // the line cannot be stalled, so a full buffer costs the new word
      RX_OVERRUN <= wr_valid && !fill.ready;
    end
  end

  assign fill.valid  = wr_valid;
  assign fill.data   = wr_data;
  assign drain.ready = RX_READY;

  char_buffer #(.W(ENTRY_W), .DEPTH(BUFFER_DEPTH)) u_buffer (
    .clock (CLOCK),
    .rst   (RST),
    .fill  (fill),
    .drain (drain)
  );

  assign RX_DATA       = drain.data[8:0];
  assign NOISE_FLAG    = drain.data[9];
  assign RX_FRAMING    = drain.data[10];
  assign RX_PARITY_ERR = drain.data[11];
  assign RX_VALID      = drain.valid;

  // transmit frame; parity replaces the top data bit
  always_comb begin
    tx_d = NINE_BITS ? TX_DATA : {1'b0, TX_DATA[7:0]};
    if (PARITY_ENABLE) begin
      if (NINE_BITS) begin
        tx_d[8] = (^TX_DATA[7:0]) ^ PARITY_ODD;
      end else begin
        tx_d[7] = (^TX_DATA[6:0]) ^ PARITY_ODD;
      end
    end
  end
  assign tx_frame = NINE_BITS ? {1'b1, tx_d, 1'b0} : {2'b11, tx_d[7:0], 1'b0};

  always_ff @(posedge CLOCK) begin
    if (RST || !TX_ENABLE) begin
      tx_busy  <= 1'b0;
      tx_shift <= TX_IDLE_FRAME;
      tx_rt    <= 4'h0;
      tx_left  <= 4'h0;
      TX_READY <= 1'b0;
    end else if (TX_READY && TX_VALID) begin
      tx_shift <= tx_frame;
      tx_left  <= nbits + FRAME_EXTRA;
      tx_rt    <= 4'h0;
      tx_busy  <= 1'b1;
      TX_READY <= 1'b0;
    end else if (tx_busy && rt_tick) begin
      tx_rt <= tx_rt + 4'h1;
      if (tx_rt == RT_LAST) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left  <= tx_left - 4'h1;
        if (tx_left == 4'h1) begin
          tx_busy  <= 1'b0;
          TX_READY <= 1'b1;
        end
      end
    end else if (!tx_busy) begin
      TX_READY <= 1'b1;
    end
  end

  // infrared: a zero is a low pulse of the programmed tick count
  assign tx_wire = INFRARED_INVERTED_ENCODING ? !(!tx_shift[0] && tx_rt < IR_PULSE_TICKS)
                                              : tx_shift[0];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      TXD_OUT <= 1'b1;
      TXD_OE  <= 1'b0;
    end else begin
      TXD_OUT <= tx_wire ^ TX_INVERT;
      TXD_OE  <= TX_ENABLE;
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  chk_data_vote: assert property (
    RX_ENABLE && rx_state == R_DATA && rt_tick && rt == RT10 |=> shift[8] == $past(data_vote))
    else $error("data bit is not the sample majority");
  chk_data_noise: assert property (
    RX_ENABLE && rx_state == R_DATA && rt_tick && rt == RT10 && !unanimous |=> noise)
    else $error("split data samples did not raise noise");
  chk_start_noise: assert property (
    RX_ENABLE && rx_state == R_START && rt_tick && rt == RT10 && |{rx_line, vote}
    |=> noise && rx_state == R_START)
    else $error("noisy start bit not flagged or dropped");
  chk_stop_frame: assert property (
    RX_ENABLE && rx_state == R_STOP && rt_tick && rt == RT10
    |=> char_done && char_frame == !$past(data_vote))
    else $error("framing error does not follow stop majority");
  chk_stop_noise: assert property (
    RX_ENABLE && rx_state == R_STOP && rt_tick && rt == RT10 && !unanimous
    |=> char_done && noise)
    else $error("split stop samples did not raise noise");
  chk_false_start: assert property (
    RX_ENABLE && rx_state == R_START && rt_tick && rt == RT7 && start_reject
    |=> rx_state == R_HUNT && rt == 4'h0)
    else $error("false start did not restart the hunt");
  chk_reject_quiet: assert property (
    RX_ENABLE && rx_state == R_START && rt_tick && rt == RT7 && start_reject |=> !noise)
    else $error("rejected start raised noise");
  chk_bit_time: assert property (
    TX_ENABLE && tx_busy && $past(tx_busy) && tx_shift != $past(tx_shift)
    |-> $past(tx_rt) == RT_LAST && $past(rt_tick))
    else $error("transmit bit shorter than sixteen ticks");
  chk_rx_off: assert property (
    !RX_ENABLE |=> rx_state == R_HUNT && !char_done)
    else $error("disabled receiver still active");
  chk_overrun: assert property (
    wr_valid && !fill.ready |=> RX_OVERRUN ##1 !RX_OVERRUN || (wr_valid && !fill.ready))
    else $error("lost character not reported");

  cov_char: cover property (char_done ##1 wr_valid);
  cov_false_start: cover property (rx_state == R_START && rt_tick && rt == RT7 && start_reject);
  cov_wake_addr: cover property (RX_ASLEEP && wake_addr);
  cov_overrun: cover property (RX_OVERRUN);
endmodule
`default_nettype wire
